// File: lrc_map.svh
// lrc_map.svh: offsets, field positions, reset values, timing counts
// assumes: included by bare name from the design modules lrc_conv and lrc_regs
`ifndef LRC_MAP_SVH
`define LRC_MAP_SVH
`define LRC_ADDR_RESULT   8'h00
`define LRC_ADDR_CONFIG   8'h01
`define LRC_RESULT_RESET  16'h0000
`define LRC_CONFIG_RESET  16'hC810
`define LRC_CFG_RO_MASK   16'h01E0
`define LRC_RN_MSB        15
`define LRC_RN_LSB        12
`define LRC_EXP_MSB       15
`define LRC_EXP_LSB       12
`define LRC_MANT_MSB      11
`define LRC_MANT_LSB      0
`define LRC_CT_BIT        11
`define LRC_MODE_MSB      10
`define LRC_MODE_LSB      9
`define LRC_OVF_BIT       8
`define LRC_CRF_BIT       7
`define LRC_FH_BIT        6
`define LRC_FL_BIT        5
`define LRC_ME_BIT        2
`define LRC_RANGE_AUTO    4'hC
`define LRC_EXP_MAX       4'hB
`define LRC_MANT_FULL     12'hFFF
`define LRC_CLK_HZ        25000000
`define LRC_CONV_SHORT_MS 100
`define LRC_CONV_LONG_MS  800
`define LRC_CONV_SHORT_CYC (`LRC_CONV_SHORT_MS * (`LRC_CLK_HZ / 1000))
`define LRC_CONV_LONG_CYC  (`LRC_CONV_LONG_MS * (`LRC_CLK_HZ / 1000))
`endif

// File: lrc_pkg.sv
// lrc_pkg.sv: types shared by the light result and configuration block
// assumes: lrc_map.svh holds the numeric constants
package lrc_pkg;
   typedef enum logic [1:0] {
      LRC_MODE_OFF    = 2'b00,
      LRC_MODE_SINGLE = 2'b01,
      LRC_MODE_CONT_A = 2'b10,
      LRC_MODE_CONT_B = 2'b11
   } lrc_mode_e;
   typedef enum logic [0:0] {
      LRC_CONV_IDLE = 1'b0,
      LRC_CONV_RUN  = 1'b1
   } lrc_conv_state_e;
   typedef enum logic [0:0] {
      LRC_BYTE_MSB = 1'b0,
      LRC_BYTE_LSB = 1'b1
   } lrc_byte_e;
endpackage : lrc_pkg

// File: lrc_conv_if.sv
// lrc_conv_if.sv: link between the register bank and the conversion core
// assumes: one clock; all signals synchronous to it
`timescale 1ns/10ps
`default_nettype none
interface lrc_conv_if;
   logic        start;
   logic        abort;
   logic        longTime;
   logic [3:0]  rangeSel;
   logic [22:0] raw;
   logic        done;
   logic        busy;
   logic [3:0]  resExp;
   logic [11:0] resMant;
   logic        resOvf;
   modport regs (output start, abort, longTime, rangeSel, raw,
                 input done, busy, resExp, resMant, resOvf);
   modport conv (input start, abort, longTime, rangeSel, raw,
                 output done, busy, resExp, resMant, resOvf);
endinterface : lrc_conv_if
`default_nettype wire

// File: lrc_conv.sv
// lrc_conv.sv: conversion timer and range/mantissa computation
// assumes: start and abort are one-cycle pulses from the register bank
`timescale 1ns/10ps
`default_nettype none
`include "lrc_map.svh"
module lrc_conv
   import lrc_pkg::*;
#(
   parameter int SHORT_CYC = `LRC_CONV_SHORT_CYC,
   parameter int LONG_CYC  = `LRC_CONV_LONG_CYC,
   parameter int CW        = 25
) (
   input  wire logic   clk,
   input  wire logic   rst_n,
   lrc_conv_if.conv    cif
);
   lrc_conv_state_e state;
   logic [CW-1:0]   cnt;
   logic [3:0]      runRange;
   logic [22:0]     shifted;
   logic [3:0]      nextExp;
   logic            nextOvf;
   logic [11:0]     nextMant;

   // ****************************************
   // range choice and mantissa
   // ****************************************
   always_comb begin
      shifted = 23'h000000;
      nextExp = `LRC_EXP_MAX;
      if (runRange < `LRC_RANGE_AUTO) begin
         nextExp = runRange;
         shifted = cif.raw >> runRange;
      end else begin
         shifted = cif.raw >> 11;
         for (int i = 11; i >= 0; i--) begin
            if ((cif.raw >> i) <= 23'h000FFF) begin
               nextExp = 4'(i);
               shifted = cif.raw >> i;
            end
         end
      end
      nextOvf  = shifted > 23'h000FFF;
      nextMant = nextOvf ? `LRC_MANT_FULL : shifted[11:0];
   end

   // ****************************************
   // conversion timer
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state    <= LRC_CONV_IDLE;
         cnt      <= '0;
         runRange <= `LRC_RANGE_AUTO;
      end else if (cif.start) begin
         state    <= LRC_CONV_RUN;
         runRange <= cif.rangeSel;
         cnt      <= cif.longTime ? CW'(LONG_CYC - 1)
                                  : CW'(SHORT_CYC - 1);
      end else if (cif.abort) begin
         state <= LRC_CONV_IDLE;
      end else begin
         case (state)
            LRC_CONV_RUN: begin
               if (cnt == '0) begin
                  state <= LRC_CONV_IDLE;
               end else begin
                  cnt <= cnt - CW'(1);
               end
            end
            default: state <= LRC_CONV_IDLE;
         endcase
      end
   end

   // ****************************************
   // result hand-off
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cif.done    <= 1'b0;
         cif.resExp  <= 4'h0;
         cif.resMant <= 12'h000;
         cif.resOvf  <= 1'b0;
      end else begin
         cif.done <= 1'b0;
         if (state == LRC_CONV_RUN && cnt == '0 && !cif.start
             && !cif.abort) begin
            cif.done    <= 1'b1;
            cif.resExp  <= nextExp;
            cif.resMant <= nextMant;
            cif.resOvf  <= nextOvf;
         end
      end
   end

   assign cif.busy = (state == LRC_CONV_RUN);

   // ****************************************
   // checks
   // ****************************************
   a_conv_length: assert property (@(posedge clk) disable iff (!rst_n)
      cif.start |=> cnt == (($past(cif.longTime) ? LONG_CYC : SHORT_CYC) - 1))
      else $error("conversion length not loaded from time select");
   a_manual_mant: assert property (@(posedge clk) disable iff (!rst_n)
      (state == LRC_CONV_RUN && cnt == '0 && !cif.start && !cif.abort
       && runRange < `LRC_RANGE_AUTO && !nextOvf)
      |=> cif.resMant == $past(shifted[11:0]) && cif.resExp == $past(runRange))
      else $error("manual range mantissa wrong");
   a_exp_bound: assert property (@(posedge clk) disable iff (!rst_n)
      cif.done |-> cif.resExp <= `LRC_EXP_MAX)
      else $error("result exponent above eleven");
   a_abort_stops: assert property (@(posedge clk) disable iff (!rst_n)
      (cif.abort && !cif.start) |=> !cif.busy ##1 !cif.done)
      else $error("conversion not stopped by abort");
endmodule : lrc_conv
`default_nettype wire

// File: lrc_regs.sv
// lrc_regs.sv: result and configuration registers of the light sensor
// assumes: a serial engine outside delivers bytes as one-cycle pulses
// Function
// - result register is read-only, writes ignored, resets to zero
// - result bits 15:12 hold exponent, bits 11:0 hold mantissa
// - mantissa is unsigned binary from zero to range full scale
// - exponent codes 0 to 11 pick twelve doubling full-scale ranges
// - one mantissa step weighs 0.01 lux times two to the exponent
// - mask bit with manual range below 1100b reports exponent zero
// - configuration register sits at 01h, resets to C810h
// - configuration write pulses abort one cycle later; a running conversion is idle one cycle after that unless the new mode starts a fresh one
// - configuration write starts a fresh conversion if mode asks
// - configuration bits 8 to 5 read-only, the rest read/write
// - each 16-bit value moves most significant byte first
// - range code 1100b selects automatic range; 1101b-1111b reserved, but the logic treats them as automatic range too
// - time select 0 gives 100 ms, 1 gives 800 ms, resets to 1
`timescale 1ns/10ps
`default_nettype none
`include "lrc_map.svh"
module lrc_regs
   import lrc_pkg::*;
#(
   parameter int SHORT_CYC = `LRC_CONV_SHORT_CYC,
   parameter int LONG_CYC  = `LRC_CONV_LONG_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        busStart,
   input  wire logic        busWrByte,
   input  wire logic [7:0]  busWrData,
   input  wire logic        busRdReq,
   input  wire logic [22:0] lightLevel,
   output var  logic [7:0]  busRdData
);
   lrc_conv_if  cif ();
   logic [15:0] cfgRw;
   logic        overflowFlag;
   logic        convReadyFlag;
   logic [3:0]  resExp;
   logic [11:0] resMant;
   logic [7:0]  pointer;
   logic        wantPtr;
   lrc_byte_e   phase;
   logic [7:0]  wrHold;
   logic [7:0]  rdHold;
   logic        wrCfg;
   logic        wrLow;
   logic        rdHigh;
   logic [15:0] wrWord;
   logic [15:0] newCfg;
   logic [15:0] cfgRead;
   logic [15:0] resultRead;
   logic [15:0] rdWord;
   logic        maskExp;
   lrc_mode_e   mode;

   lrc_conv #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC),
      .CW        (25)
   ) u_conv (
      .clk   (clk),
      .rst_n (rst_n),
      .cif   (cif)
   );

   // ****************************************
   // byte sequencing
   // ****************************************
   assign wrLow  = busWrByte && !wantPtr && phase == LRC_BYTE_LSB;
   assign wrWord = {wrHold, busWrData};
   assign wrCfg  = wrLow && pointer == `LRC_ADDR_CONFIG;
   assign rdHigh = busRdReq && phase == LRC_BYTE_MSB;
   assign newCfg = wrWord & ~`LRC_CFG_RO_MASK;
   assign mode   = lrc_mode_e'(cfgRw[`LRC_MODE_MSB:`LRC_MODE_LSB]);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pointer <= `LRC_ADDR_RESULT;
         wantPtr <= 1'b0;
         phase   <= LRC_BYTE_MSB;
         wrHold  <= 8'h00;
      end else if (busStart) begin
         wantPtr <= 1'b1;
         phase   <= LRC_BYTE_MSB;
      end else if (busWrByte && wantPtr) begin
         pointer <= busWrData;
         wantPtr <= 1'b0;
      end else if (busWrByte) begin
         wrHold <= (phase == LRC_BYTE_MSB) ? busWrData : wrHold;
         phase  <= (phase == LRC_BYTE_MSB) ? LRC_BYTE_LSB : LRC_BYTE_MSB;
      end else if (busRdReq) begin
         wantPtr <= 1'b0;
         phase   <= (phase == LRC_BYTE_MSB) ? LRC_BYTE_LSB : LRC_BYTE_MSB;
      end
   end

   // ****************************************
   // register read mux
   // ****************************************
   assign maskExp = cfgRw[`LRC_ME_BIT] &&
                    cfgRw[`LRC_RN_MSB:`LRC_RN_LSB] < `LRC_RANGE_AUTO;
   assign resultRead = {maskExp ? 4'h0 : resExp, resMant};
   assign cfgRead = {cfgRw[15:9], overflowFlag, convReadyFlag,
                     2'b00, cfgRw[4:0]};

   always_comb begin
      case (pointer)
         `LRC_ADDR_RESULT: rdWord = resultRead;
         `LRC_ADDR_CONFIG: rdWord = cfgRead;
         default:          rdWord = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busRdData <= 8'h00;
         rdHold    <= 8'h00;
      end else if (busRdReq && !busStart) begin
         busRdData <= rdHigh ? rdWord[15:8] : rdHold;
         rdHold    <= rdHigh ? rdWord[7:0] : rdHold;
      end
   end

   // ****************************************
   // configuration register
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfgRw <= `LRC_CONFIG_RESET & ~`LRC_CFG_RO_MASK;
      end else if (wrCfg && !busStart) begin
         cfgRw <= newCfg;
      end else if (cif.done && mode == LRC_MODE_SINGLE) begin
         cfgRw[`LRC_MODE_MSB:`LRC_MODE_LSB] <= LRC_MODE_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         overflowFlag  <= 1'b0;
         convReadyFlag <= 1'b0;
      end else begin
         overflowFlag <= cif.done ? cif.resOvf : overflowFlag;
         if (cif.done) begin
            convReadyFlag <= 1'b1;
         end else if (rdHigh && !busStart &&
                      pointer == `LRC_ADDR_CONFIG) begin
            convReadyFlag <= 1'b0;
         end
      end
   end

   // ****************************************
   // result register and conversion control
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         resExp  <= 4'h0;
         resMant <= 12'h000;
      end else if (cif.done) begin
         resExp  <= cif.resExp;
         resMant <= cif.resMant;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cif.start <= 1'b0;
         cif.abort <= 1'b0;
      end else begin
         cif.abort <= wrCfg && !busStart;
         cif.start <= (wrCfg && !busStart &&
                       newCfg[`LRC_MODE_MSB:`LRC_MODE_LSB] != 2'b00) ||
                      (cif.done && mode[1] && !wrCfg);
      end
   end

   assign cif.longTime = cfgRw[`LRC_CT_BIT];
   assign cif.rangeSel = cfgRw[`LRC_RN_MSB:`LRC_RN_LSB];
   assign cif.raw      = lightLevel;

   // ****************************************
   // checks
   // ****************************************
   sequence s_cfg_write;
      wrCfg && !busStart;
   endsequence
   sequence s_restart;
      cif.abort ##0 cif.start;
   endsequence

   a_result_ro: assert property (@(posedge clk) disable iff (!rst_n)
      (wrLow && pointer == `LRC_ADDR_RESULT && !cif.done)
      |=> resExp == $past(resExp) && resMant == $past(resMant))
      else $error("result register changed by host write");
   a_reset_vals: assert property (@(posedge clk)
      !rst_n |=> cfgRead == `LRC_CONFIG_RESET &&
                 {resExp, resMant} == `LRC_RESULT_RESET)
      else $error("register reset value wrong");
   a_cfg_ro_bits: assert property (@(posedge clk) disable iff (!rst_n)
      s_cfg_write |=> cfgRw[15:9] == $past(wrWord[15:9]) &&
                      cfgRw[4:0] == $past(wrWord[4:0]) &&
                      cfgRw[8:5] == 4'h0)
      else $error("configuration write stored wrong bits");
   a_abort_restart: assert property (@(posedge clk) disable iff (!rst_n)
      (s_cfg_write and (newCfg[10:9] != 2'b00)) |=> s_restart ##1 cif.busy)
      else $error("configuration write did not restart conversion");
   a_write_aborts: assert property (@(posedge clk) disable iff (!rst_n)
      (s_cfg_write and (newCfg[10:9] == 2'b00)) |=> cif.abort ##1 !cif.busy)
      else $error("configuration write did not abort conversion");
   a_exp_masked: assert property (@(posedge clk) disable iff (!rst_n)
      (rdHigh && !busStart && pointer == `LRC_ADDR_RESULT && maskExp)
      |=> busRdData[7:4] == 4'h0)
      else $error("masked exponent not reported as zero");
   a_byte_order: assert property (@(posedge clk) disable iff (!rst_n)
      (rdHigh && !busStart) ##1 (busRdReq && !busStart)
      |=> busRdData == $past(rdWord[7:0], 2))
      else $error("register bytes out of order");
   a_result_field: assert property (@(posedge clk) disable iff (!rst_n)
      cif.done |=> resExp == $past(cif.resExp) && resMant == $past(cif.resMant))
      else $error("result fields not captured");
endmodule : lrc_regs
`default_nettype wire

// File: lrc_host_model.sv
// lrc_host_model.sv: host side of the register byte port
// assumes: tasks called by the bench; strobes move at the falling edge
`timescale 1ns/10ps
`default_nettype none
module lrc_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] busRdData,
   output var  logic       busStart,
   output var  logic       busWrByte,
   output var  logic [7:0] busWrData,
   output var  logic       busRdReq
);
   initial begin
      busStart  = 1'b0;
      busWrByte = 1'b0;
      busWrData = 8'h00;
      busRdReq  = 1'b0;
   end
   // ****************************************
   // transfers
   // ****************************************
   task automatic open_xfer(input logic [7:0] ptr);
      @(negedge clk);
      busStart = 1'b1;
      @(negedge clk);
      busStart  = 1'b0;
      busWrByte = 1'b1;
      busWrData = ptr;
   endtask : open_xfer
   task automatic wr16(input logic [7:0] ptr, input logic [15:0] val);
      open_xfer(ptr);
      @(negedge clk);
      busWrData = val[15:8];
      @(negedge clk);
      busWrData = val[7:0];
      @(negedge clk);
      busWrByte = 1'b0;
      busWrData = ~busWrData;
   endtask : wr16
   task automatic rd16(input logic [7:0] ptr, output logic [15:0] val);
      open_xfer(ptr);
      @(negedge clk);
      busWrByte = 1'b0;
      busWrData = ~busWrData;
      busRdReq  = 1'b1;
      @(negedge clk);
      val[15:8] = busRdData;
      @(negedge clk);
      val[7:0] = busRdData;
      busRdReq = 1'b0;
   endtask : rd16
endmodule : lrc_host_model
`default_nettype wire

// File: light_result_config_regs_bench.sv
// light_result_config_regs_bench.sv: self-checking bench of lrc_regs
// assumes: lrc_host_model drives the byte port; short conversion counts
`timescale 1ns/10ps
`default_nettype none
module light_result_config_regs_bench;
   localparam int          SHORT    = 20;
   localparam int          LONG     = 40;
   localparam logic [22:0] LIGHT    = 23'h003456;
   localparam logic [3:0]  AUTO_EXP = 4'h2;
   logic        clk = 1'b0;
   logic        rst_n;
   logic [22:0] lightLevel;
   logic        busStart;
   logic        busWrByte;
   logic [7:0]  busWrData;
   logic        busRdReq;
   logic [7:0]  busRdData;
   logic [15:0] rd;
   int          mismatches = 0;
   int          numChecks  = 0;
   always #20 clk = ~clk;
   lrc_regs #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut_u (
      .clk        (clk),
      .rst_n      (rst_n),
      .busStart   (busStart),
      .busWrByte  (busWrByte),
      .busWrData  (busWrData),
      .busRdReq   (busRdReq),
      .lightLevel (lightLevel),
      .busRdData  (busRdData)
   );
   lrc_host_model host_u (
      .clk       (clk),
      .busRdData (busRdData),
      .busStart  (busStart),
      .busWrByte (busWrByte),
      .busWrData (busWrData),
      .busRdReq  (busRdReq)
   );
   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      numChecks++;
      if (seen !== want) begin
         mismatches++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic summarize;
      if (mismatches == 0 && numChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   function automatic logic ovf(input logic [3:0] e);
      return (LIGHT >> e) > 23'h000FFF;
   endfunction : ovf
   function automatic logic [15:0] expRes(input logic [3:0] e);
      logic [22:0] s;
      s = LIGHT >> e;
      if (ovf(e)) begin
         return {e, 12'hFFF};
      end
      return {e, s[11:0]};
   endfunction : expRes
   // polls the ready flag, bounded
   task automatic waitReady(output logic [15:0] cfg);
      int n;
      n = 0;
      cfg = 16'h0000;
      while (cfg[7] !== 1'b1) begin
         host_u.rd16(8'h01, cfg);
         n++;
         if (n > 30) begin
            mismatches++;
            summarize();
         end
      end
   endtask : waitReady
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      lightLevel = LIGHT;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      host_u.rd16(8'h00, rd);
      check(rd, 16'h0000);
      host_u.rd16(8'h01, rd);
      check(rd, 16'hC810);
      host_u.wr16(8'h00, 16'h1234);
      host_u.rd16(8'h00, rd);
      check(rd, 16'h0000);
      host_u.rd16(8'h05, rd);
      check(rd, 16'h0000);
      host_u.wr16(8'h01, 16'hF9FF);
      host_u.rd16(8'h01, rd);
      check(rd, 16'hF81F);
      for (int e = 0; e < 12; e++) begin
         host_u.wr16(8'h01, {e[3:0], 12'h200});
         waitReady(rd);
         check(rd, {e[3:0], 3'b000, ovf(e[3:0]), 8'h80});
         host_u.rd16(8'h00, rd);
         check(rd, expRes(e[3:0]));
      end
      host_u.wr16(8'h01, {4'h3, 12'h204});
      waitReady(rd);
      host_u.rd16(8'h00, rd);
      check(rd, expRes(4'h3) & 16'h0FFF);
      for (int c = 12; c < 14; c++) begin
         host_u.wr16(8'h01, {c[3:0], 12'h204});
         waitReady(rd);
         host_u.rd16(8'h00, rd);
         check(rd, expRes(AUTO_EXP));
      end
      host_u.wr16(8'h01, {4'h1, 12'hA00});
      repeat (SHORT + 5) @(negedge clk);
      host_u.rd16(8'h01, rd);
      check(rd & 16'h0080, 16'h0000);
      waitReady(rd);
      host_u.rd16(8'h00, rd);
      check(rd, expRes(4'h1));
      lightLevel = 23'h000123;
      host_u.wr16(8'h01, {4'h0, 12'hC00});
      repeat (5) @(negedge clk);
      host_u.wr16(8'h01, 16'h0800);
      repeat (LONG + 10) @(negedge clk);
      host_u.rd16(8'h01, rd);
      check(rd, {4'h0, 1'b1, 2'b00, ovf(4'h1), 8'h00});
      host_u.rd16(8'h00, rd);
      check(rd, expRes(4'h1));
      host_u.wr16(8'h01, {4'h0, 12'h200});
      waitReady(rd);
      host_u.rd16(8'h00, rd);
      check(rd, 16'h0123);
      host_u.wr16(8'h01, 16'h0600);
      waitReady(rd);
      check(rd, 16'h0680);
      waitReady(rd);
      check(rd, 16'h0680);
      host_u.rd16(8'h00, rd);
      check(rd, 16'h0123);
      summarize();
   end
endmodule : light_result_config_regs_bench
`default_nettype wire
